//--- src/hsc_pkg.sv
// hsc_pkg: constants, register map and carrier types of the host-side control block.
// assumes a 25 MHz system clock; all users refer to names as hsc_pkg::name.
package hsc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // timing
   localparam int CLK_MHZ    = 25;
   localparam int READY_US   = 100;                   // ready after reset release
   localparam int READY_CYC  = READY_US * CLK_MHZ;    // longest time, exact here
   localparam int RELOCK_US  = 1000;                  // modelled pll/barrier relock
   localparam int RELOCK_CYC = RELOCK_US * CLK_MHZ;
   localparam int PRIME_CYC  = 3;                     // synchroniser fill time

   ////////////////////////////////////////////////////////////////////////////
   // serial host port frame: read flag, 7-bit address, 8-bit data, msb first
   localparam int FRAME_BITS = 16;
   localparam int CMD_BITS   = 8;

   ////////////////////////////////////////////////////////////////////////////
   // register offsets
   localparam logic [6:0] A_CHAIN = 7'h01;
   localparam logic [6:0] A_MODE  = 7'h02;
   localparam logic [6:0] A_STAT  = 7'h03;
   localparam logic [6:0] A_IEN   = 7'h05;
   localparam logic [6:0] A_PRESCALE_PATTERN  = 7'h08;
   localparam logic [6:0] A_PDIV  = 7'h09;
   localparam logic [6:0] A_CPV   = 7'h0a;
   localparam logic [6:0] A_FDIV  = 7'h0b;
   localparam logic [6:0] A_FSEQ  = 7'h0c;
   localparam logic [6:0] A_LOCK  = 7'h0d;
   localparam logic [6:0] A_HOOK  = 7'h12;
   localparam logic [6:0] A_LAST  = 7'h25;

   ////////////////////////////////////////////////////////////////////////////
   // reset values, field positions and reserved-bit masks
   localparam logic [7:0] IEN_RST   = 8'hff;          // every source enabled
   localparam logic [7:0] CFG_RST   = 8'h00;
   localparam logic [7:0] CPV_MASK  = 8'hf7;          // bit 3 reserved
   localparam logic [7:0] FDIV_MASK = 8'h7f;          // bit 7 reserved
   localparam int         LOCK_BIT  = 7;
   localparam int         SLEEP_BIT = 6;
   localparam int         CHG_BIT   = 3;
   localparam int         APOL_BIT  = 3;
   localparam int         SYNC_LOSS_FLAG_BIT  = 1;

   ////////////////////////////////////////////////////////////////////////////
   // carriers
   typedef struct packed {
      logic [7:0] pre_seq;
      logic [7:0] pre_div;
      logic [7:0] cp_vco;
      logic [7:0] fb_div;
      logic [7:0] fb_seq;
      logic [2:0] fb_rst;
   } hsc_pll_t;

   typedef struct packed {
      logic [7:0] chain;
      logic [7:0] mode;
      logic [7:0] hook;
   } hsc_cfg_t;

   typedef enum logic [1:0] {
      RC_IDLE   = 2'b01,
      RC_RELOCK = 2'b10
   } hsc_rc_t;

endpackage : hsc_pkg

//--- src/hsc_sync_edge.sv
// hsc_sync_edge: two-flop synchronisers with edge detection for pins.
// assumes inputs are asynchronous to clk_sys; edges are held off until the chain is filled.
`timescale 1ns/1ps
module hsc_sync_edge #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rst_b,
   // pins in, synchronised view out
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] level,
   output logic      [W-1:0] rise,
   output logic      [W-1:0] fall
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;
   logic [W-1:0] prev_q;
   logic [1:0]   prime_q;

   if (W < 1) begin : bad_width_g
      $error("hsc_sync_edge: W must be at least 1");
   end

   // first stage is read only by the second
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         meta_q <= '0;
         sync_q <= '0;
         prev_q <= '0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // suppress false edges while reset zeros drain out of the chain
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         prime_q <= 2'h0;
      end else if (prime_q != 2'(hsc_pkg::PRIME_CYC)) begin
         prime_q <= prime_q + 2'h1;
      end
   end

   assign level = sync_q;
   assign rise  = (prime_q == 2'(hsc_pkg::PRIME_CYC)) ? (sync_q & ~prev_q) : '0;
   assign fall  = (prime_q == 2'(hsc_pkg::PRIME_CYC)) ? (~sync_q & prev_q) : '0;
endmodule : hsc_sync_edge

//--- src/hsc_ctrl.sv
// hsc_ctrl: host-side control, serial host port slave, interrupt and clock-rate registers.
// assumes all pins are asynchronous; the serial clock is sampled by clk_sys (>= 4x faster).
`timescale 1ns/1ps
module hsc_ctrl #(
   parameter int RELOCK_CYC = hsc_pkg::RELOCK_CYC
) (
   // clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst_b,
   // serial host port
   input  wire logic             ser_clk,
   input  wire logic             ser_frame,
   input  wire logic             ser_din,
   output logic                  ser_dout,
   output logic                  ser_dout_oe,
   // strap pins
   input  wire logic             ms_pin,
   input  wire logic             type_pin,
   input  wire logic             serial_clock_mode_pin,
   // event sources
   input  wire logic [3:0]       gpio_in,
   input  wire logic             ring_in,
   input  wire logic             ring_mon_in,
   input  wire logic             line_event_in,
   input  wire logic             barrier_sync_in,
   input  wire logic             pll_lock_in,
   input  wire logic             line_sleep_in,
   // interrupt pin, open drain
   output logic                  irq_n_o,
   output logic                  irq_n_oe,
   // status and configuration out
   output logic                  dev_ready,
   output logic [2:0]            port_mode,
   output hsc_pkg::hsc_pll_t     pll_cfg,
   output logic                  pll_restart,
   output hsc_pkg::hsc_cfg_t     cfg
);
   if (RELOCK_CYC < 2 || RELOCK_CYC > 32'h00ffffff) begin : bad_relock_g
      $error("hsc_ctrl: bad RELOCK_CYC");
   end
   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [15:0] lvl, rise, fall;
   hsc_sync_edge #(.W(16)) hsc_sync_edge_i (
      .clk_sys  (clk_sys),
      .rst_b    (rst_b),
      .async_in ({ser_clk, ser_frame, ser_din, ms_pin, type_pin, serial_clock_mode_pin,
                  gpio_in, ring_mon_in, line_event_in, barrier_sync_in, ring_in,
                  pll_lock_in, line_sleep_in}),
      .level    (lvl),
      .rise     (rise),
      .fall     (fall)
   );
   wire logic       sclk_rise = rise[15];
   wire logic       sclk_fall = fall[15];
   wire logic       frame     = lvl[14];
   wire logic       din       = lvl[13];
   wire logic       ms_edge   = rise[12] | fall[12];
   wire logic [2:0] mode_lvl  = lvl[12:10];
   ////////////////////////////////////////////////////////////////////////////
   // soft reset from master/slave pin edges
   logic soft_rst_q;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) soft_rst_q <= 1'b0;
      else        soft_rst_q <= ms_edge;
   end
   // readiness counter, restarted by any reset
   logic [11:0] ready_cnt_q;
   logic        dev_ready_q;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ready_cnt_q <= 12'h000;
         dev_ready_q <= 1'b0;
      end else if (soft_rst_q) begin
         ready_cnt_q <= 12'h000;
         dev_ready_q <= 1'b0;
      end else if (!dev_ready_q) begin
         ready_cnt_q <= ready_cnt_q + 12'h001;
         dev_ready_q <= (ready_cnt_q == 12'(hsc_pkg::READY_CYC - 1));
      end
   end
   assign dev_ready = dev_ready_q;
   // port mode tracks the final strap levels
   logic [2:0] port_mode_q;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) port_mode_q <= 3'h0;
      else        port_mode_q <= mode_lvl;
   end
   assign port_mode = port_mode_q;
   ////////////////////////////////////////////////////////////////////////////
   // serial frame engine: the only path into the registers
   logic [4:0]  bit_cnt_q;
   logic [15:0] sh_in_q;
   logic [7:0]  rd_sh_q;
   logic        rd_act_q, dout_q;
   wire logic [7:0] cmd     = {sh_in_q[6:0], din};
   wire logic       cmd_end = frame & sclk_rise & (bit_cnt_q == 5'(hsc_pkg::CMD_BITS - 1));
   wire logic       rd_load = cmd_end & cmd[7] & dev_ready_q;
   wire logic       wr_en   = frame & sclk_rise & dev_ready_q & ~sh_in_q[14] &
                              (bit_cnt_q == 5'(hsc_pkg::FRAME_BITS - 1));
   wire logic [6:0] wr_addr = sh_in_q[13:7];
   wire logic [7:0] wr_data = {sh_in_q[6:0], din};
   logic [7:0] rd_val;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         bit_cnt_q <= 5'h00;
         sh_in_q   <= 16'h0000;
      end else if (!frame) begin
         bit_cnt_q <= 5'h00;
      end else if (sclk_rise && bit_cnt_q < 5'(hsc_pkg::FRAME_BITS)) begin
         bit_cnt_q <= bit_cnt_q + 5'h01;
         sh_in_q   <= {sh_in_q[14:0], din};
      end
   end
   // read data leaves msb first on falling serial clock edges
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rd_sh_q  <= 8'h00;
         rd_act_q <= 1'b0;
         dout_q   <= 1'b0;
      end else if (!frame) begin
         rd_act_q <= 1'b0;
      end else if (rd_load) begin
         rd_sh_q  <= rd_val;
         rd_act_q <= 1'b1;
      end else if (rd_act_q && sclk_fall) begin
         dout_q  <= rd_sh_q[7];
         rd_sh_q <= {rd_sh_q[6:0], 1'b0};
      end
   end
   assign ser_dout    = dout_q;
   assign ser_dout_oe = frame & rd_act_q;
   ////////////////////////////////////////////////////////////////////////////
   // registers
   logic [7:0] chain_q, mode_q, ien_q, hook_q;
   logic [7:0] prescale_pattern_q, pdiv_q, cpv_q, fdiv_q, fseq_q;
   logic [2:0] frst_q;
   wire logic  wr_lock = wr_en & (wr_addr == hsc_pkg::A_LOCK);
   wire logic  apply   = wr_lock & wr_data[hsc_pkg::CHG_BIT];
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b || soft_rst_q) begin
         chain_q <= hsc_pkg::CFG_RST;
         mode_q  <= hsc_pkg::CFG_RST;
         ien_q   <= hsc_pkg::IEN_RST;
         hook_q  <= hsc_pkg::CFG_RST;
         prescale_pattern_q  <= hsc_pkg::CFG_RST;
         pdiv_q  <= hsc_pkg::CFG_RST;
         cpv_q   <= hsc_pkg::CFG_RST;
         fdiv_q  <= hsc_pkg::CFG_RST;
         fseq_q  <= hsc_pkg::CFG_RST;
         frst_q  <= 3'h0;
      end else if (wr_en) begin
         case (wr_addr)
            hsc_pkg::A_CHAIN: chain_q <= wr_data;
            hsc_pkg::A_MODE:  mode_q  <= wr_data;
            hsc_pkg::A_IEN:   ien_q   <= wr_data;
            hsc_pkg::A_HOOK:  hook_q  <= wr_data;
            hsc_pkg::A_PRESCALE_PATTERN:  prescale_pattern_q  <= wr_data;
            hsc_pkg::A_PDIV:  pdiv_q  <= wr_data;
            hsc_pkg::A_CPV:   cpv_q   <= wr_data & hsc_pkg::CPV_MASK;
            hsc_pkg::A_FDIV:  fdiv_q  <= wr_data & hsc_pkg::FDIV_MASK;
            hsc_pkg::A_FSEQ:  fseq_q  <= wr_data;
            hsc_pkg::A_LOCK:  frst_q  <= wr_data[2:0];
            default: ;
         endcase
      end
   end
   assign cfg = '{chain: chain_q, mode: mode_q, hook: hook_q};
   ////////////////////////////////////////////////////////////////////////////
   // rate change: shadow settings only reach the pll on the trigger
   hsc_pkg::hsc_rc_t  rc_q;
   hsc_pkg::hsc_pll_t pll_q;
   logic [23:0]       relock_q;
   logic              restart_q;
   wire hsc_pkg::hsc_pll_t shadow = '{pre_seq: prescale_pattern_q, pre_div: pdiv_q, cp_vco: cpv_q,
                                      fb_div: fdiv_q, fb_seq: fseq_q, fb_rst: wr_data[2:0]};
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b || soft_rst_q) begin
         rc_q      <= hsc_pkg::RC_IDLE;
         pll_q     <= '0;
         relock_q  <= 24'h000000;
         restart_q <= 1'b0;
      end else begin
         restart_q <= apply;
         case (rc_q)
            hsc_pkg::RC_IDLE: if (apply) begin
               pll_q    <= shadow;
               relock_q <= 24'(RELOCK_CYC - 1);
               rc_q     <= hsc_pkg::RC_RELOCK;
            end
            hsc_pkg::RC_RELOCK: begin
               // lock and sync are held off while the pll re-acquires
               if (relock_q == 24'h000000) rc_q <= hsc_pkg::RC_IDLE;
               else                        relock_q <= relock_q - 24'h000001;
            end
            default: rc_q <= hsc_pkg::RC_IDLE;
         endcase
      end
   end
   assign pll_cfg     = pll_q;
   assign pll_restart = restart_q;
   wire logic lock_ok = lvl[1] & (rc_q == hsc_pkg::RC_IDLE);
   wire logic sync_ok = lvl[3] & lock_ok;
   ////////////////////////////////////////////////////////////////////////////
   // interrupt status: sticky, cleared by a read, a new event wins over the clear
   logic [7:0] stat_q;
   logic       sync_prev_q;
   wire logic  sync_lost = sync_prev_q & ~sync_ok;
   wire logic [7:0] ev  = {rise[9:6], rise[5], rise[4], sync_lost, rise[2]};
   wire logic  stat_clr = rd_load & (cmd[6:0] == hsc_pkg::A_STAT);
   wire logic [7:0] irq_mask = {ien_q[7:4], ien_q[0], ien_q[2:0]};
   // prev starts high so the unsynced barrier after reset raises an event
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b || soft_rst_q) begin
         stat_q      <= 8'h00;
         sync_prev_q <= 1'b1;
      end else begin
         sync_prev_q <= sync_ok;
         stat_q      <= (stat_clr ? 8'h00 : stat_q) | ev;
      end
   end
   assign irq_n_o  = 1'b0;
   assign irq_n_oe = |(stat_q & irq_mask);
   // read mux; unmapped and out-of-range addresses read zero
   always_comb begin
      case (cmd[6:0])
         hsc_pkg::A_CHAIN: rd_val = chain_q;
         hsc_pkg::A_MODE:  rd_val = mode_q;
         hsc_pkg::A_STAT:  rd_val = stat_q;
         hsc_pkg::A_IEN:   rd_val = ien_q;
         hsc_pkg::A_PRESCALE_PATTERN:  rd_val = prescale_pattern_q;
         hsc_pkg::A_PDIV:  rd_val = pdiv_q;
         hsc_pkg::A_CPV:   rd_val = cpv_q;
         hsc_pkg::A_FDIV:  rd_val = fdiv_q;
         hsc_pkg::A_FSEQ:  rd_val = fseq_q;
         hsc_pkg::A_LOCK:  rd_val = {lock_ok, lvl[0], 2'h0,
                                     rc_q == hsc_pkg::RC_RELOCK, frst_q};
         hsc_pkg::A_HOOK:  rd_val = hook_q;
         default:          rd_val = 8'h00;
      endcase
   end
   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   ready_time_a: assert property (!dev_ready_q |-> ready_cnt_q < 12'(hsc_pkg::READY_CYC))
      else $error("not ready within the ready time");
   no_early_a: assert property (!dev_ready_q |=> !$past(wr_en) && !$past(rd_load))
      else $error("access taken before ready");
   ms_reset_a: assert property (ms_edge |=> ##1 !dev_ready_q && ien_q == 8'hff)
      else $error("pin edge did not reset");
   irq_on_a: assert property (|(ev & irq_mask) && !soft_rst_q |=> irq_n_oe)
      else $error("enabled event did not raise interrupt");
   ien_default_a: assert property (soft_rst_q |=> ien_q == 8'hff [*2])
      else $error("enables not defaulted");
   stat_clear_a: assert property (stat_clr && ev == 8'h00 && !soft_rst_q
                                  |=> stat_q == 8'h00 && !irq_n_oe)
      else $error("status read did not clear");
   set_wins_a: assert property (|ev && !soft_rst_q |=> (stat_q & $past(ev)) == $past(ev))
      else $error("event lost");
   mode_follow_a: assert property (##1 port_mode == $past(mode_lvl))
      else $error("port mode not following pins");
   relock_a: assert property (apply && rc_q == hsc_pkg::RC_IDLE && !soft_rst_q
                              |=> pll_restart && !lock_ok ##1 !lock_ok)
      else $error("lock not dropped on rate change");
   apply_a: assert property (apply && rc_q == hsc_pkg::RC_IDLE && !soft_rst_q
                             |=> pll_cfg == $past(shadow))
      else $error("pll settings not applied");
   hook_keep_a: assert property (apply && !soft_rst_q |=> $stable(hook_q))
      else $error("hook settings disturbed by rate change");
   range_a: assert property (rd_load && cmd[6:0] > hsc_pkg::A_LAST |=> rd_sh_q == 8'h00)
      else $error("out-of-range read not zero");
   ready_c:  cover property ($rose(dev_ready_q));
   read_c:   cover property (stat_clr && irq_n_oe);
   rate_c:   cover property (apply ##1 rc_q == hsc_pkg::RC_RELOCK);
   msrst_c:  cover property (ms_edge && dev_ready_q);
endmodule : hsc_ctrl

//--- verif/hsc_host_model.sv
// hsc_host_model: behavioural host controller on the serial host port.
// assumes the bench calls xfer only after the device start-up time; one frame at a time.
`timescale 1ns/1ps
module hsc_host_model (
   // serial host port, host side
   input  wire logic ser_dout,
   output logic      ser_clk,
   output logic      ser_frame,
   output logic      ser_din
);
   ////////////////////////////////////////////////////////////////////////////
   // idle: link clock stands still low outside frames
   initial begin
      ser_clk   = 1'b0;
      ser_frame = 1'b0;
      ser_din   = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // one frame: read flag, address, data, msb first, 320 ns link clock
   // read data is sampled late in the high phase, since it follows falling edges
   task automatic xfer(input logic rd, input logic [6:0] addr, input logic [7:0] wdata,
                       output logic [7:0] rdata);
      logic [15:0] word;
      word      = {rd, addr, wdata};
      rdata     = 8'h00;
      ser_frame = 1'b1;
      for (int k = 15; k >= 0; k--) begin
         ser_din = (rd && k < 8) ? ~ser_din : word[k];      // no stale data on reads
         #160;
         ser_clk = 1'b1;
         #159;
         if (k < 8) rdata[k] = ser_dout;
         #1;
         ser_clk = 1'b0;
      end
      #160;
      ser_frame = 1'b0;
      ser_din   = ~ser_din;                                   // released line keeps moving
      #160;
   endtask : xfer
endmodule : hsc_host_model

//--- verif/hsc_ctrl_bench.sv
// hsc_ctrl_bench: self-checking bench for the host-side control block.
// assumes hsc_pkg, hsc_ctrl and hsc_host_model are compiled first.
`timescale 1ns/1ps
module hsc_ctrl_bench;
   localparam int RELOCK = 400;                     // shortened relock for simulation
   logic              clk_sys, rst_b, ms_pin, type_pin, serial_clock_mode_pin;
   logic [3:0]        gpio_in;
   logic              ring_in, ring_mon_in, line_event_in, barrier_sync_in;
   logic              pll_lock_in, line_sleep_in, sync_ok;
   logic              ser_clk, ser_frame, ser_din, ser_dout, ser_dout_oe;
   logic              irq_n_o, irq_n_oe, dev_ready, pll_restart, irq_line, dout_line;
   logic [2:0]        port_mode;
   hsc_pkg::hsc_pll_t pll_cfg;
   hsc_pkg::hsc_cfg_t cfg;
   logic [7:0]        ev, v, feedback_reset_count;
   logic [7:0]        exp_q [8];
   logic [6:0]        addrs [8];
   int                errors, samples_checked, restarts;

   ////////////////////////////////////////////////////////////////////////////
   // event pins from one vector; sync loss is a drop of the sync pin
   assign {gpio_in, ring_mon_in, line_event_in, ring_in} = {ev[7:2], ev[0]};
   assign barrier_sync_in = sync_ok & ~ev[1];
   // open-drain interrupt with pull-up; undriven data line shows a moving pattern
   assign irq_line  = irq_n_oe ? irq_n_o : 1'b1;
   assign dout_line = ser_dout_oe ? ser_dout : ~ser_din;

   hsc_ctrl #(.RELOCK_CYC(RELOCK)) hsc_ctrl_i (
      .clk_sys(clk_sys), .rst_b(rst_b), .ser_clk(ser_clk), .ser_frame(ser_frame),
      .ser_din(ser_din), .ser_dout(ser_dout), .ser_dout_oe(ser_dout_oe), .ms_pin(ms_pin),
      .type_pin(type_pin), .serial_clock_mode_pin(serial_clock_mode_pin),
      .gpio_in(gpio_in), .ring_in(ring_in), .ring_mon_in(ring_mon_in),
      .line_event_in(line_event_in), .barrier_sync_in(barrier_sync_in),
      .pll_lock_in(pll_lock_in), .line_sleep_in(line_sleep_in), .irq_n_o(irq_n_o),
      .irq_n_oe(irq_n_oe), .dev_ready(dev_ready), .port_mode(port_mode),
      .pll_cfg(pll_cfg), .pll_restart(pll_restart), .cfg(cfg));

   hsc_host_model hsc_host_model_i (
      .ser_dout(dout_line), .ser_clk(ser_clk), .ser_frame(ser_frame), .ser_din(ser_din));

   ////////////////////////////////////////////////////////////////////////////
   // clock, restart-pulse counter and watchdog
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      if (pll_restart === 1'b1) restarts++;
   end

   // the run needs about 12000 cycles; a hang gets well over three times that
   initial begin
      #(40000 * 40);
      errors++;
      final_report();
   end

   ////////////////////////////////////////////////////////////////////////////
   // shared tasks and expectation helpers
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #2;
   endtask : step

   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] dummy;
      hsc_host_model_i.xfer(1'b0, a, d, dummy);
   endtask : wr

   task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
      logic [7:0] got;
      hsc_host_model_i.xfer(1'b1, a, 8'h00, got);
      check(got, exp);
   endtask : rd_chk

   // raise one event source for a few cycles, then let it fall back
   task automatic fire(input int i);
      ev[i] = 1'b1;
      step(6);
      ev = 8'h00;
      step(6);
   endtask : fire

   // enable bit that unmasks status bit i; the ring monitor shares the ring enable
   function automatic logic [7:0] en_for(input int i);
      return ((i == 3) ? 8'h01 : (8'h01 << i)) | 8'h08;
   endfunction : en_for

   function automatic logic [7:0] rmask(input logic [6:0] a);
      if (a == hsc_pkg::A_CPV) return hsc_pkg::CPV_MASK;
      if (a == hsc_pkg::A_FDIV) return hsc_pkg::FDIV_MASK;
      return 8'hff;
   endfunction : rmask

   task automatic final_report();
      $display("comparisons %0d, mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : final_report

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      v = 8'($urandom(51));
      {errors, samples_checked, restarts} = '0;
      {rst_b, ms_pin, ev, sync_ok, line_sleep_in} = '0;
      pll_lock_in = 1'b1;
      type_pin = 1'($urandom);
      serial_clock_mode_pin = 1'($urandom);
      addrs = '{hsc_pkg::A_CHAIN, hsc_pkg::A_MODE, hsc_pkg::A_PRESCALE_PATTERN, hsc_pkg::A_PDIV,
                hsc_pkg::A_CPV, hsc_pkg::A_FDIV, hsc_pkg::A_FSEQ, hsc_pkg::A_HOOK};
      step(8);
      rst_b = 1'b1;
      step(6);
      check(irq_line, 1'b0);
      sync_ok = 1'b1;
      step(hsc_pkg::READY_CYC - 6);
      check(dev_ready, 1'b1);
      check(port_mode, {ms_pin, type_pin, serial_clock_mode_pin});
      rd_chk(hsc_pkg::A_IEN, hsc_pkg::IEN_RST);
      rd_chk(hsc_pkg::A_HOOK, hsc_pkg::CFG_RST);
      rd_chk(hsc_pkg::A_STAT, 8'h02);
      check(irq_line, 1'b1);
      wr(hsc_pkg::A_IEN, 8'h08);
      v = 8'($urandom_range(7));
      fire(v);
      check(irq_line, 1'b1);
      rd_chk(hsc_pkg::A_STAT, 8'h01 << v);
      // each source alone, unmasked: pin pulls low, status read releases it
      for (int i = 0; i < 8; i++) begin
         wr(hsc_pkg::A_IEN, en_for(i));
         fire(i);
         check(irq_line, 1'b0);
         rd_chk(hsc_pkg::A_STAT, 8'h01 << i);
         check(irq_line, 1'b1);
      end
      // random contents in every writable place but the enable and lock registers, reserved bits read as zero
      foreach (addrs[j]) begin
         exp_q[j] = 8'($urandom) & rmask(addrs[j]);
         wr(addrs[j], exp_q[j] | ~rmask(addrs[j]));
         rd_chk(addrs[j], exp_q[j]);
      end
      check(cfg, {exp_q[0], exp_q[1], exp_q[7]});
      wr(7'h26, 8'h5a);
      rd_chk(7'h26, 8'h00);
      wr(7'h04, 8'ha5);
      rd_chk(7'h04, 8'h00);
      exp_q[7] = (exp_q[7] & 8'hf0) | 8'h05;
      wr(hsc_pkg::A_HOOK, exp_q[7]);
      rd_chk(hsc_pkg::A_HOOK, exp_q[7]);
      // rate change; the host's long wait is shortened along with the relock time
      line_sleep_in = 1'($urandom);
      feedback_reset_count = 8'($urandom_range(7));
      wr(hsc_pkg::A_LOCK, feedback_reset_count | 8'h08);
      check(restarts, 1);
      check(pll_cfg, {exp_q[2], exp_q[3], exp_q[4], exp_q[5], exp_q[6], feedback_reset_count[2:0]});
      rd_chk(hsc_pkg::A_LOCK, {1'b0, line_sleep_in, 3'b001, feedback_reset_count[2:0]});
      step(RELOCK);
      rd_chk(hsc_pkg::A_STAT, 8'h02);
      rd_chk(hsc_pkg::A_LOCK, {1'b1, line_sleep_in, 3'b000, feedback_reset_count[2:0]});
      check(cfg.hook, exp_q[7]);
      // a lock loss outside a rate change reads as no lock and raises sync loss
      pll_lock_in = 1'b0;
      step(6);
      rd_chk(hsc_pkg::A_LOCK, {1'b0, line_sleep_in, 3'b000, feedback_reset_count[2:0]});
      pll_lock_in = 1'b1;
      rd_chk(hsc_pkg::A_STAT, 8'h02);
      // an edge on the master/slave pin restarts the device
      type_pin = 1'($urandom);
      ms_pin = ~ms_pin;
      step(10);
      check(dev_ready, 1'b0);
      step(hsc_pkg::READY_CYC);
      check(dev_ready, 1'b1);
      check(port_mode, {ms_pin, type_pin, serial_clock_mode_pin});
      rd_chk(hsc_pkg::A_CHAIN, hsc_pkg::CFG_RST);
      rd_chk(hsc_pkg::A_IEN, hsc_pkg::IEN_RST);
      final_report();
   end
endmodule : hsc_ctrl_bench
